/* File: core/mwc_pkg.sv */
// package: constants, types and timing of the memory write-cycle control block
package mwc_pkg;

    // ****************************************************************
    // clock and documented delays
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 100;
    localparam int WINIT_NS = 75;
    localparam int WE_ON_NS = 60;
    localparam int WE_OFF_NS = 210;

    // least times round up, longest times round down, never below one cycle
    localparam int WINIT_CYC = ((WINIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1) ? 1 :
        (WINIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WE_ON_CYC = ((WE_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1) ? 1 :
        (WE_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WE_OFF_CYC = (WE_OFF_NS / CLK_PERIOD_NS < 1) ? 1 : WE_OFF_NS / CLK_PERIOD_NS;

    // ****************************************************************
    // memory geometry
    // ****************************************************************
    localparam int WORD_ADDR_W = 11;
    localparam int PROT_FIELD_HI = 10;
    localparam int PROT_FIELD_LO = 7;
    localparam int SYNC_STAGES = 2;

    // ****************************************************************
    // data select codes {bit1, bit0}
    // ****************************************************************
    localparam logic [1:0] DSEL_CU = 2'h0;
    localparam logic [1:0] DSEL_IO_SUBSYSTEM = 2'h1;
    localparam logic [1:0] DSEL_CUB = 2'h2;
    localparam logic [1:0] DSEL_PE = 2'h3;

    // ****************************************************************
    // register map
    // ****************************************************************
    localparam logic [4:0] OFS_CTRL = 5'h00;
    localparam logic [4:0] OFS_STATUS = 5'h04;
    localparam logic [4:0] OFS_MASK = 5'h08;
    localparam logic [4:0] OFS_STATE = 5'h0c;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    localparam int CTRL_ENABLE_BIT = 0;
    localparam logic CTRL_RESET = 1'h1;
    localparam int EV_W = 3;
    localparam int EV_PROT_BIT = 0;
    localparam int EV_WDONE_BIT = 1;
    localparam int EV_RDONE_BIT = 2;
    localparam logic [2:0] MASK_RESET = 3'h0;
    localparam int ST_LATCH_BIT = 0;
    localparam int ST_BUSY_BIT = 1;
    localparam int ST_WEN_BIT = 2;
    localparam int ST_OUTER_BIT = 3;
    localparam int ST_INNER_BIT = 4;
    localparam int ST_ADDR_LO = 16;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_WRITE = 3'h2,
        ST_READ = 3'h4
    } mwc_state_e;

    // outputs toward the memory array
    typedef struct packed {
        logic [WORD_ADDR_W-1:0] addr;
        logic init_n;
        logic outer_we;
        logic inner_we;
    } mwc_mem_ctl_s;

endpackage

/* File: core/mwc_sync.sv */
// two-flop synchroniser for a vector of independent pin levels
`timescale 1ns/10ps
`default_nettype none
module mwc_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] sync_r;

    // reset value is zero; active-low pins therefore read as asserted until two edges pass
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            meta_r <= '0;
            sync_r <= '0;
        end
        else
        begin
            meta_r <= async_in;
            sync_r <= meta_r;
        end
    end

    assign sync_out = sync_r;
endmodule
`default_nettype wire

/* File: core/mwc_delay_line.sv */
// clocked stand-in for the write-cycle delay line and its timing taps
`timescale 1ns/10ps
`default_nettype none
module mwc_delay_line #(
    parameter int WINIT_CYC = mwc_pkg::WINIT_CYC,
    parameter int WE_ON_CYC = mwc_pkg::WE_ON_CYC,
    parameter int WE_OFF_CYC = mwc_pkg::WE_OFF_CYC
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // launch
    input wire logic launch,
    // taps
    output logic winit_tap,
    output logic we_window,
    output logic cycle_end
);
    localparam int CNT_W = $clog2(WE_OFF_CYC + 1);

    logic [CNT_W-1:0] cnt_r;

    generate
        if (WINIT_CYC < 1 || WE_ON_CYC < 1 || WE_OFF_CYC <= WE_ON_CYC || WINIT_CYC > WE_OFF_CYC)
        begin : g_bad
            $error("delay line taps out of order");
        end
    endgenerate

    // count of whole cycles since launch, zero when idle
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            cnt_r <= '0;
        else if (launch)
            cnt_r <= CNT_W'(1);
        else if (cycle_end)
            cnt_r <= '0;
        else if (cnt_r != '0)
            cnt_r <= cnt_r + CNT_W'(1);
    end

    assign winit_tap = (cnt_r == CNT_W'(WINIT_CYC));
    assign we_window = (cnt_r >= CNT_W'(WE_ON_CYC)) && (cnt_r < CNT_W'(WE_OFF_CYC));
    assign cycle_end = (cnt_r == CNT_W'(WE_OFF_CYC));
endmodule
`default_nettype wire

/* File: core/mwc_top.sv */
// memory write-cycle control: start, protect check, initiate pulse, half-word enables
//
// Functional notes
// - select plus initiate launches the timing pulse
// - 11-bit word address forwarded to memory
// - protected low 128 words block enables, set latch
// - protect latch is status only, never blocks
// - latch holds until protect-error reset
// - initiate needs write, enable, no transfer, tap
// - enable flip-flop rests set, cleared on error
// - write initiate tap delays about 75 ns
// - reads activate memory without the write delay
// - initiate pulse leaves the block active low
// - outer and inner enables cover their bit groups
// - low half-select bit sets its latch
// - half latches gate outer and inner enables
// - controller or io sources force both enables
// - enables valid inside the 60-210 ns window
`timescale 1ns/10ps
`default_nettype none
module mwc_top #(
    parameter int ADDR_W = 5,
    parameter int WINIT_CYC = mwc_pkg::WINIT_CYC,
    parameter int WE_ON_CYC = mwc_pkg::WE_ON_CYC,
    parameter int WE_OFF_CYC = mwc_pkg::WE_OFF_CYC
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address and data
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // controller pins
    input wire logic memory_select,
    input wire logic initiate_memory_cycle,
    input wire logic read_write_control,
    input wire logic [mwc_pkg::WORD_ADDR_W-1:0] word_address_bits,
    input wire logic protect_request_n,
    input wire logic protect_error_reset,
    input wire logic outer_half_select_n,
    input wire logic inner_half_select_n,
    input wire logic data_select_bit0,
    input wire logic data_select_bit1,
    input wire logic transfer_active,
    // memory side
    output mwc_pkg::mwc_mem_ctl_s mem_ctl,
    output logic timing_initiate_pulse,
    output logic protect_error_latch,
    output logic irq
);
    localparam int AW = mwc_pkg::WORD_ADDR_W;
    localparam int SW = AW + 10;
    localparam int EW = mwc_pkg::EV_W;

    // the register decode reads address bits 4:2, so a narrower bus cannot reach the map
    generate
        if (ADDR_W < 5)
        begin : g_bad_addr
            $error("register address narrower than the map");
        end
    endgenerate

    // ****************************************************************
    // pin synchronisation
    // ****************************************************************
    logic [SW-1:0] pins_raw;
    logic [SW-1:0] pins_s;
    logic s_msel;
    logic s_imc;
    logic s_rw;
    logic [AW-1:0] s_addr;
    logic s_prot_n;
    logic s_perr_rst;
    logic s_osel_n;
    logic s_isel_n;
    logic [1:0] s_dsel;
    logic s_xfer;

    assign pins_raw = {memory_select, initiate_memory_cycle, read_write_control,
        word_address_bits, protect_request_n, protect_error_reset, outer_half_select_n,
        inner_half_select_n, data_select_bit1, data_select_bit0, transfer_active};

    mwc_sync #(.WIDTH(SW)) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in(pins_raw),
        .sync_out(pins_s)
    );

    assign {s_msel, s_imc, s_rw, s_addr, s_prot_n, s_perr_rst, s_osel_n, s_isel_n,
        s_dsel, s_xfer} = pins_s;

    // ****************************************************************
    // cycle sequencing
    // ****************************************************************
    mwc_pkg::mwc_state_e state_r;
    mwc_pkg::mwc_state_e state_nxt;
    logic imc_prev_r;
    logic rw_r;
    logic xfer_r;
    logic [1:0] dsel_r;
    logic [AW-1:0] addr_r;
    logic wen_ff_r;
    logic outer_lat_r;
    logic inner_lat_r;
    logic prot_latch_r;
    logic tip_r;
    logic init_r;
    logic outer_we_r;
    logic inner_we_r;
    logic ctrl_en_r;
    logic start;
    logic prot_hit;
    logic winit_tap;
    logic we_window;
    logic cycle_end;
    logic force_full;
    logic we_ok;
    logic init_write;
    logic [EW-1:0] events;

    // level edge so a held initiate starts only one cycle
    assign start = s_msel && s_imc && !imc_prev_r && (state_r == mwc_pkg::ST_IDLE)
        && ctrl_en_r;
    // protect check runs on writes only; reads never see it
    assign prot_hit = start && !s_rw && !s_prot_n
        && (s_addr[mwc_pkg::PROT_FIELD_HI:mwc_pkg::PROT_FIELD_LO] == '0);
    assign force_full = (dsel_r == mwc_pkg::DSEL_CU) || (dsel_r == mwc_pkg::DSEL_IO_SUBSYSTEM);
    assign we_ok = (state_r == mwc_pkg::ST_WRITE) && we_window && wen_ff_r && !rw_r && !xfer_r;
    assign init_write = (state_r == mwc_pkg::ST_WRITE) && !rw_r && wen_ff_r && !xfer_r
        && winit_tap;

    mwc_delay_line #(
        .WINIT_CYC(WINIT_CYC),
        .WE_ON_CYC(WE_ON_CYC),
        .WE_OFF_CYC(WE_OFF_CYC)
    ) u_delay (
        .aclk(aclk),
        .aresetn(aresetn),
        .launch(start && !s_rw),
        .winit_tap(winit_tap),
        .we_window(we_window),
        .cycle_end(cycle_end)
    );

    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            mwc_pkg::ST_IDLE:
                if (start)
                    state_nxt = s_rw ? mwc_pkg::ST_READ : mwc_pkg::ST_WRITE;
            mwc_pkg::ST_WRITE:
                if (cycle_end)
                    state_nxt = mwc_pkg::ST_IDLE;
            mwc_pkg::ST_READ:
                state_nxt = mwc_pkg::ST_IDLE;
            default:
                state_nxt = mwc_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_r <= mwc_pkg::ST_IDLE;
            imc_prev_r <= 1'h0;
        end
        else
        begin
            state_r <= state_nxt;
            imc_prev_r <= s_imc;
        end
    end

    // read/write and data select are taken as they stand at the start
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rw_r <= 1'h1;
            xfer_r <= 1'h0;
            dsel_r <= mwc_pkg::DSEL_PE;
            addr_r <= '0;
        end
        else if (start)
        begin
            rw_r <= s_rw;
            xfer_r <= s_xfer;
            dsel_r <= s_dsel;
            addr_r <= s_addr;
        end
    end

    // enable flip-flop rests set, drops on a protect hit and sets again once the state is back in idle
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            wen_ff_r <= 1'h1;
        else if (prot_hit)
            wen_ff_r <= 1'h0;
        else if (state_r == mwc_pkg::ST_IDLE)
            wen_ff_r <= 1'h1;
    end

    // half latches are set by a low select at the start and hold until the next start reloads them
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            outer_lat_r <= 1'h0;
            inner_lat_r <= 1'h0;
        end
        else if (start)
        begin
            outer_lat_r <= !s_osel_n;
            inner_lat_r <= !s_isel_n;
        end
    end

    // status only: it steers nothing, so later writes still run
    // a hit in the clearing cycle wins over the reset
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            prot_latch_r <= 1'h0;
        else if (prot_hit)
            prot_latch_r <= 1'h1;
        else if (s_perr_rst)
            prot_latch_r <= 1'h0;
    end

    // ****************************************************************
    // memory outputs
    // ****************************************************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            tip_r <= 1'h0;
            init_r <= 1'h0;
            outer_we_r <= 1'h0;
            inner_we_r <= 1'h0;
        end
        else
        begin
            tip_r <= start;
            init_r <= init_write || (start && s_rw);
            outer_we_r <= we_ok && (force_full || outer_lat_r);
            inner_we_r <= we_ok && (force_full || inner_lat_r);
        end
    end

    assign mem_ctl.addr = addr_r;
    assign mem_ctl.init_n = !init_r;
    assign mem_ctl.outer_we = outer_we_r;
    assign mem_ctl.inner_we = inner_we_r;
    assign timing_initiate_pulse = tip_r;
    assign protect_error_latch = prot_latch_r;

    // ****************************************************************
    // axi4-lite register slave and interrupt
    // ****************************************************************
    logic aw_got_r;
    logic w_got_r;
    logic [ADDR_W-1:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    logic [EW-1:0] status_r;
    logic [EW-1:0] mask_r;
    logic do_write;
    logic wr_ctrl;
    logic wr_status;
    logic wr_mask;
    logic wr_known;
    logic [EW-1:0] w1c;
    logic [31:0] state_word;
    logic [31:0] rd_word;
    logic rd_known;

    function automatic logic [4:0] word_ofs(input logic [ADDR_W-1:0] a);
        word_ofs = {a[4:2], 2'h0};
    endfunction

    assign s_axi_awready = !aw_got_r && !bvalid_r;
    assign s_axi_wready = !w_got_r && !bvalid_r;
    assign s_axi_arready = !rvalid_r;
    assign do_write = aw_got_r && w_got_r && !bvalid_r;
    assign wr_ctrl = do_write && (word_ofs(awaddr_r) == mwc_pkg::OFS_CTRL) && wstrb_r[0];
    assign wr_status = do_write && (word_ofs(awaddr_r) == mwc_pkg::OFS_STATUS) && wstrb_r[0];
    assign wr_mask = do_write && (word_ofs(awaddr_r) == mwc_pkg::OFS_MASK) && wstrb_r[0];
    assign wr_known = (word_ofs(awaddr_r) == mwc_pkg::OFS_CTRL)
        || (word_ofs(awaddr_r) == mwc_pkg::OFS_STATUS)
        || (word_ofs(awaddr_r) == mwc_pkg::OFS_MASK)
        || (word_ofs(awaddr_r) == mwc_pkg::OFS_STATE);
    assign w1c = wr_status ? wdata_r[EW-1:0] : '0;
    assign events = {(state_r == mwc_pkg::ST_READ),
        ((state_r == mwc_pkg::ST_WRITE) && cycle_end), prot_hit};

    assign state_word = {5'h0, addr_r, 11'h0, inner_lat_r, outer_lat_r, wen_ff_r,
        (state_r != mwc_pkg::ST_IDLE), prot_latch_r};
    assign rd_known = (word_ofs(s_axi_araddr) <= mwc_pkg::OFS_STATE) && (ADDR_W < 5 ||
        s_axi_araddr[ADDR_W-1:0] < ADDR_W'(16));
    assign rd_word = (word_ofs(s_axi_araddr) == mwc_pkg::OFS_CTRL) ? {31'h0, ctrl_en_r} :
        (word_ofs(s_axi_araddr) == mwc_pkg::OFS_STATUS) ? {29'h0, status_r} :
        (word_ofs(s_axi_araddr) == mwc_pkg::OFS_MASK) ? {29'h0, mask_r} : state_word;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_got_r <= 1'h0;
            w_got_r <= 1'h0;
            awaddr_r <= '0;
            wdata_r <= 32'h0;
            wstrb_r <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_got_r <= 1'h1;
                awaddr_r <= s_axi_awaddr;
            end
            else if (do_write)
                aw_got_r <= 1'h0;
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_got_r <= 1'h1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            else if (do_write)
                w_got_r <= 1'h0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid_r <= 1'h0;
            bresp_r <= mwc_pkg::RESP_OKAY;
            rvalid_r <= 1'h0;
            rdata_r <= 32'h0;
            rresp_r <= mwc_pkg::RESP_OKAY;
        end
        else
        begin
            if (do_write)
            begin
                bvalid_r <= 1'h1;
                bresp_r <= wr_known ? mwc_pkg::RESP_OKAY : mwc_pkg::RESP_SLVERR;
            end
            else if (s_axi_bready)
                bvalid_r <= 1'h0;
            if (s_axi_arvalid && s_axi_arready)
            begin
                rvalid_r <= 1'h1;
                rdata_r <= rd_known ? rd_word : 32'h0;
                rresp_r <= rd_known ? mwc_pkg::RESP_OKAY : mwc_pkg::RESP_SLVERR;
            end
            else if (s_axi_rready)
                rvalid_r <= 1'h0;
        end
    end

    // events set over a same-cycle write-one clear
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl_en_r <= mwc_pkg::CTRL_RESET;
            mask_r <= mwc_pkg::MASK_RESET;
            status_r <= '0;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_en_r <= wdata_r[mwc_pkg::CTRL_ENABLE_BIT];
            if (wr_mask)
                mask_r <= wdata_r[EW-1:0];
            status_r <= (status_r & ~w1c) | events;
        end
    end

    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign irq = |(status_r & mask_r);

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    tip_follows_start_a: assert property (start |=> timing_initiate_pulse)
        else $error("timing initiate pulse missing after start");
    addr_forward_a: assert property (start |=> mem_ctl.addr == $past(s_addr))
        else $error("word address not forwarded");
    prot_sets_latch_a: assert property (prot_hit |=> prot_latch_r)
        else $error("protect hit did not set latch");
    prot_blocks_we_a: assert property (prot_hit |-> ##1 (!outer_we_r && !inner_we_r)[*3])
        else $error("write enable after protect hit");
    latch_no_block_a: assert property ((start && !s_rw && !prot_hit && !s_xfer
        && prot_latch_r) |-> ##2 !mem_ctl.init_n)
        else $error("latched error blocked a write");
    latch_clear_a: assert property ($fell(prot_latch_r) |-> $past(s_perr_rst))
        else $error("latch cleared without reset");
    init_cause_a: assert property (($fell(mem_ctl.init_n) && !rw_r) |->
        $past(winit_tap && wen_ff_r && !xfer_r))
        else $error("write initiate without its conditions");
    read_fast_a: assert property ((start && s_rw) |=> !mem_ctl.init_n)
        else $error("read initiate delayed");
    init_pulse_a: assert property (!mem_ctl.init_n |=> mem_ctl.init_n)
        else $error("initiate pulse longer than one cycle");
    half_gate_a: assert property ((outer_we_r && $past(dsel_r) == mwc_pkg::DSEL_PE)
        |-> $past(outer_lat_r))
        else $error("outer enable without its latch");
    force_full_a: assert property ((outer_we_r || inner_we_r) && force_full
        |-> (outer_we_r && inner_we_r))
        else $error("controller or io write not full width");
    we_window_a: assert property ((start && !s_rw && !prot_hit && !s_xfer
        && s_dsel == mwc_pkg::DSEL_CU) |-> ##2 outer_we_r ##1 !outer_we_r)
        else $error("write enable outside its window");
endmodule
`default_nettype wire

/* File: sim/mwc_mem_model.sv */
// memory array stand-in: records each initiate pulse with its enables
`timescale 1ns/10ps
`default_nettype none
module mwc_mem_model (
    // clock
    input wire logic aclk,
    // memory side
    input wire mwc_pkg::mwc_mem_ctl_s mem_ctl,
    // observed access
    output logic seen,
    output logic [12:0] seen_word
);
    // low level starts the array
    always_ff @(posedge aclk)
    begin
        seen <= !mem_ctl.init_n;
        seen_word <= {mem_ctl.addr, mem_ctl.outer_we, mem_ctl.inner_we};
    end
endmodule
`default_nettype wire

/* File: sim/mwc_tb_top.sv */
// self-checking bench for the memory write-cycle control block
`timescale 1ns/10ps
`default_nettype none
module mwc_tb_top;
    // ****************************************
    // signals, design and memory
    // ****************************************
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
    logic msel, imc, rw, prn, per, ohn, ihn, ds1, ds0, xfer, seen, plat, sprot, mk, en;
    logic arready, rvalid, tip, latch, irq;
    logic [4:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    logic [10:0] wa;
    logic [6:0] p;
    logic [12:0] seen_word;
    logic [33:0] q[$];
    mwc_pkg::mwc_mem_ctl_s mem_ctl;
    int n_fail, samples_checked, n_tip;
    mwc_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .memory_select(msel), .initiate_memory_cycle(imc), .read_write_control(rw),
        .word_address_bits(wa), .protect_request_n(prn), .protect_error_reset(per),
        .outer_half_select_n(ohn), .inner_half_select_n(ihn), .data_select_bit0(ds0),
        .data_select_bit1(ds1), .transfer_active(xfer), .mem_ctl(mem_ctl),
        .timing_initiate_pulse(tip), .protect_error_latch(latch), .irq(irq));
    mwc_mem_model mem (.aclk(aclk), .mem_ctl(mem_ctl), .seen(seen), .seen_word(seen_word));
    always #50 aclk = ~aclk;
    task automatic chk(input logic [33:0] v, input logic [33:0] e);
        samples_checked++;
        if (v !== e)
        begin
            n_fail++;
            $display("MISMATCH t=%0t got %h exp %h", $time, v, e);
        end
    endtask
    // an empty queue means a result nobody asked for
    task automatic take(input logic [33:0] v);
        if (q.size() != 0)
            chk(v, q.pop_front());
        else
            chk(34'h0, 34'h1);
    endtask
    task automatic axi(input logic wr, input logic [4:0] ad, input logic [31:0] d,
        input logic [33:0] e);
        logic [4:0] tk;
        q.push_back(e);
        @(posedge aclk);
        {awaddr, araddr, wdata} <= {ad, ad, d};
        {awvalid, wvalid, bready} <= {3{wr}};
        {arvalid, rready} <= {2{!wr}};
        tk = 5'h0;
        while (!tk[1] && !tk[0])
        begin
            @(negedge aclk);
            tk = {awvalid & awready, wvalid & wready, arvalid & arready, bready & bvalid,
                rready & rvalid};
            @(posedge aclk);
            if (tk[4]) awvalid <= 1'b0;
            if (tk[3]) wvalid <= 1'b0;
            if (tk[2]) arvalid <= 1'b0;
            if (tk[1]) bready <= 1'b0;
            if (tk[0]) rready <= 1'b0;
        end
    endtask
    // p is {read, protect_n, outer_n, inner_n, select code, transfer}
    task automatic mcyc(input logic [10:0] ad, input logic [6:0] pv);
        logic hit, f;
        int t0;
        hit = en && !pv[6] && !pv[5] && ad[10:7] == 4'h0;
        f = pv[2:1] == mwc_pkg::DSEL_CU || pv[2:1] == mwc_pkg::DSEL_IO_SUBSYSTEM;
        t0 = n_tip;
        if (en && (pv[6] || (!hit && !pv[0])))
            q.push_back({21'h0, ad, !pv[6] && (f || !pv[4]), !pv[6] && (f || !pv[3])});
        @(posedge aclk);
        {rw, prn, ohn, ihn, ds1, ds0, xfer} <= pv;
        wa <= ad;
        {msel, imc} <= 2'h3;
        repeat (8) @(posedge aclk);
        {msel, imc} <= 2'h0;
        repeat (4) @(posedge aclk);
        plat = plat | hit;
        sprot = sprot | hit;
        chk(latch, plat);
        chk(irq, sprot & mk);
        chk(34'(n_tip - t0), {33'h0, en});
    endtask
    task automatic end_sim;
        $display("checked %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // ****************************************
    // monitor, watchdog and tests
    // ****************************************
    always @(posedge aclk)
    begin
        if (bvalid && bready)
            take({bresp, 32'h0});
        if (rvalid && rready)
            take({rresp, rdata});
        if (seen)
            take({21'h0, seen_word});
        if (tip)
            n_tip++;
    end
    initial
    begin
        repeat (3000) @(posedge aclk);
        n_fail++;
        end_sim;
    end
    initial
    begin
        {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, msel, imc, rw} = 10'h0;
        {ohn, ihn, ds1, ds0, xfer, per, prn, en, plat, sprot, mk} = 11'h18;
        {awaddr, araddr, wdata, wa, p} = 60'h0;
        n_fail = 0;
        samples_checked = 0;
        n_tip = 0;
        void'($urandom(32'hcbe43bd0));
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
        axi(1'b0, mwc_pkg::OFS_CTRL, 32'h0, 34'h1);
        axi(1'b0, mwc_pkg::OFS_MASK, 32'h0, 34'h0);
        axi(1'b0, 5'h10, 32'h0, {mwc_pkg::RESP_SLVERR, 32'h0});
        axi(1'b1, 5'h14, 32'h1, {mwc_pkg::RESP_SLVERR, 32'h0});
        axi(1'b1, mwc_pkg::OFS_MASK, 32'h1, 34'h0);
        mk = 1'b1;
        $display("test registers done");
        for (int c = 0; c < 4; c++)
            mcyc(11'h400 + 11'(c), {4'h5, 2'(c), 1'b0});
        mcyc(11'h07f, 7'h00);
        mcyc(11'h080, 7'h06);
        for (int i = 0; i < 24; i++)
        begin
            p = 7'($urandom);
            if (p[6]) p[0] = 1'b0;
            mcyc(11'($urandom) & (i[0] ? 11'h07f : 11'h7ff), p);
        end
        $display("test cycles done");
        axi(1'b1, mwc_pkg::OFS_STATUS, 32'h1, 34'h0);
        sprot = 1'b0;
        chk(irq, 1'b0);
        per <= 1'b1;
        repeat (4) @(posedge aclk);
        per <= 1'b0;
        repeat (3) @(posedge aclk);
        plat = 1'b0;
        chk(latch, 1'b0);
        axi(1'b1, mwc_pkg::OFS_MASK, 32'h0, 34'h0);
        mk = 1'b0;
        mcyc(11'h000, 7'h00);
        axi(1'b1, mwc_pkg::OFS_CTRL, 32'h0, 34'h0);
        en = 1'b0;
        mcyc(11'h100, 7'h06);
        axi(1'b1, mwc_pkg::OFS_CTRL, 32'h1, 34'h0);
        en = 1'b1;
        mcyc(11'h100, 7'h06);
        chk(q.size(), 34'h0);
        $display("test protect and enable done");
        end_sim;
    end
endmodule
`default_nettype wire
